// ### hw/bfcn_decoder.sv
// What this block does
// RULE1: taken branch loads return pointer into fetch counter
// RULE2: five delay slots, target runs six cycles later
// RULE3: clear field bits, pass other bits unchanged
// RULE4: low position is field least significant bit
// RULE5: high position is field most significant bit
// RULE6: register form: high bits 0-4, low 5-9
// RULE7: upper 22 first_source bits must be zero
// RULE8: operand bits numbered 0 lsb to 31
// RULE9: clear runs on shift units, two opfields
// RULE10: clear result visible one cycle after issue
// RULE11: compare on logic units, four operand encodings
// RULE12: compare writes one if equal, else zero
// RULE13: delay slots of any branch are uninterruptible
// RULE14: never two taken branches per packet
// RULE15: taken branch sets nmi enable; false is nop (a false one here still restarts the uninterruptible window)
`default_nettype none
module bfcn_decoder #(
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // dispatch
    input wire logic issue_valid_i,
    input wire logic [31:0] issue_word_i,
    input wire bfcn_pkg::bfcn_unit_t issue_unit_i,
    input wire logic cond_true_i,
    input wire logic other_branch_i,
    // operands
    input wire logic [31:0] first_src_i,
    input wire logic [39:0] second_src_i,
    input wire logic [31:0] nrp_i,
    // interrupt controller
    input wire logic nmi_enable_clear_i,
    // fetch and interrupt status
    output logic pfc_load_o,
    output logic [31:0] pfc_o,
    output logic nmi_enable_o,
    output logic no_interrupt_o,
    output logic target_exec_o,
    // register file write
    output logic wr_en_o,
    output bfcn_pkg::bfcn_unit_t wr_unit_o,
    output logic [4:0] wr_dst_o,
    output logic [31:0] wr_data_o
);
    import bfcn_pkg::*;

    generate
        if (DATA_W != 32)
        begin : g_width_check
            $error("bfcn_decoder supports only DATA_W of 32");
        end
    endgenerate

    // ****************************************************************
    // decode
    // ****************************************************************
    wire logic [31:0] iw = issue_word_i;
    wire logic on_shift = issue_unit_i == BFCN_SHIFT_A || issue_unit_i == BFCN_SHIFT_B;
    wire logic on_logic = issue_unit_i == BFCN_LOGIC_A || issue_unit_i == BFCN_LOGIC_B;
    wire logic [6:0] l_op = iw[11:5];

    wire logic is_nrp = issue_valid_i && issue_unit_i == BFCN_SHIFT_B
        && iw[BFCN_SECOND_SOURCE_MSB:BFCN_SECOND_SOURCE_LSB] == BFCN_NRP_SECOND_SOURCE
        && iw[BFCN_FIRST_SOURCE_MSB:BFCN_FIRST_SOURCE_LSB] == BFCN_NRP_FIRST_SOURCE
        && iw[11:6] == BFCN_NRP_OP && iw[5:2] == BFCN_S_TAIL_REG;
    wire logic nrp_taken = is_nrp && cond_true_i; // RULE15
    // any branch issued opens the uninterruptible window, taken or not
    wire logic any_branch = is_nrp || other_branch_i; // RULE13

    wire logic is_clr_c = issue_valid_i && cond_true_i && on_shift
        && iw[7:6] == BFCN_CLR_CST_OP && iw[5:2] == BFCN_S_TAIL_CST; // RULE9
    wire logic is_clr_r = issue_valid_i && cond_true_i && on_shift
        && iw[11:6] == BFCN_CLR_REG_OP && iw[5:2] == BFCN_S_TAIL_REG; // RULE9
    wire logic is_clr = is_clr_c || is_clr_r;

    wire logic cmp_code = l_op == BFCN_CMP_RR || l_op == BFCN_CMP_CR
        || l_op == BFCN_CMP_RL || l_op == BFCN_CMP_CL;
    wire logic is_cmp = issue_valid_i && cond_true_i && on_logic
        && iw[4:2] == BFCN_L_TAIL && cmp_code; // RULE11

    // ****************************************************************
    // bit field clear operands
    // ****************************************************************
    // upper 22 first_source bits are ignored; software keeps them zero
    wire logic [4:0] fld_lo = is_clr_r ? first_src_i[BFCN_RLO_MSB:BFCN_RLO_LSB]
        : iw[BFCN_FIRST_SOURCE_MSB:BFCN_FIRST_SOURCE_LSB]; // RULE4 RULE6 RULE7
    wire logic [4:0] fld_hi = is_clr_r ? first_src_i[BFCN_RHI_MSB:BFCN_RHI_LSB]
        : iw[BFCN_CSTB_MSB:BFCN_CSTB_LSB]; // RULE5 RULE6 RULE7

    bfcn_clr_if clr_bus ();
    assign clr_bus.second_src = second_src_i[31:0];
    assign clr_bus.low_pos = fld_lo;
    assign clr_bus.high_pos = fld_hi;

    bfcn_clear_unit u_clear (
        .clr (clr_bus)
    );

    // ****************************************************************
    // equality compare operands
    // ****************************************************************
    wire logic [4:0] cst5 = iw[BFCN_FIRST_SOURCE_MSB:BFCN_FIRST_SOURCE_LSB];
    wire logic first_source_cst = l_op == BFCN_CMP_CR || l_op == BFCN_CMP_CL;
    wire logic second_source_long = l_op == BFCN_CMP_RL || l_op == BFCN_CMP_CL;
    wire logic [39:0] cmp_a = first_source_cst ? bfcn_sext5(cst5) : bfcn_sext32(first_src_i);
    wire logic [39:0] cmp_b = second_source_long ? second_src_i : bfcn_sext32(second_src_i[31:0]);
    wire logic cmp_eq = second_source_long ? (cmp_a == cmp_b) : (cmp_a[31:0] == cmp_b[31:0]);

    wire logic [31:0] next_wr_data = is_clr ? clr_bus.result : {31'h00000000, cmp_eq}; // RULE12

    // ****************************************************************
    // result write, one cycle after issue
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_en_o <= 1'b0;
            wr_unit_o <= BFCN_SHIFT_A;
            wr_dst_o <= 5'h00;
            wr_data_o <= 32'h00000000;
        end
        else
        begin
            wr_en_o <= is_clr || is_cmp; // RULE10
            wr_unit_o <= issue_unit_i;
            wr_dst_o <= iw[BFCN_DST_MSB:BFCN_DST_LSB];
            wr_data_o <= next_wr_data; // RULE3 RULE10 RULE12
        end
    end

    // ****************************************************************
    // branch through the nmi return pointer
    // ****************************************************************
    logic [2:0] slot_cnt;
    logic nrp_pending;
    wire logic slot_last = slot_cnt == 3'h1;
    wire logic [2:0] next_slot_cnt = any_branch ? BFCN_DELAY_SLOTS
        : (slot_cnt != 3'h0 ? slot_cnt - 3'h1 : 3'h0);
    // two taken branches in one packet are undefined; this one wins the fetch counter
    wire logic [31:0] next_pfc = nrp_taken ? nrp_i : pfc_o; // RULE14

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            slot_cnt <= 3'h0;
            nrp_pending <= 1'b0;
            pfc_load_o <= 1'b0;
            pfc_o <= BFCN_PFC_RESET;
            no_interrupt_o <= 1'b0;
            target_exec_o <= 1'b0;
        end
        else
        begin
            slot_cnt <= next_slot_cnt; // RULE2
            // a later branch inside the slots restarts the window and drops this target
            nrp_pending <= nrp_taken || (nrp_pending && !slot_last && !any_branch); // RULE2
            pfc_load_o <= nrp_taken; // RULE1
            pfc_o <= next_pfc; // RULE1
            no_interrupt_o <= next_slot_cnt != 3'h0; // RULE13
            target_exec_o <= nrp_pending && slot_last && !any_branch; // RULE2
        end
    end

    // the set from a taken branch beats a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            nmi_enable_o <= BFCN_NMI_ENABLE_RESET;
        end
        else if (nrp_taken)
        begin
            nmi_enable_o <= 1'b1; // RULE15
        end
        else if (nmi_enable_clear_i)
        begin
            nmi_enable_o <= 1'b0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [31:0] chk_sec;
    logic [4:0] chk_lo;
    logic [4:0] chk_hi;
    always_ff @(posedge clk_i)
    begin
        chk_sec <= second_src_i[31:0];
        chk_lo <= fld_lo;
        chk_hi <= fld_hi;
    end
    wire logic [31:0] chk_mask = (32'hFFFFFFFF >> (5'h1F - chk_hi)) & (32'hFFFFFFFF << chk_lo);

    AST_PFC_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
        nrp_taken |=> pfc_load_o && pfc_o == $past(nrp_i))
        else $error("fetch counter not loaded from return pointer");
    AST_TARGET_SIX: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
        nrp_taken ##1 (!any_branch)[*5] |=> target_exec_o)
        else $error("target did not execute six cycles after branch");
    AST_TARGET_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
        nrp_taken |=> !target_exec_o[*5])
        else $error("target executed inside delay slots");
    AST_SLOTS_LOCKED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE13
        any_branch |=> no_interrupt_o[*5])
        else $error("delay slot left interruptible");
    AST_CLR_VALUE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
        is_clr |=> wr_en_o && wr_data_o == (chk_sec & ~chk_mask))
        else $error("bit field clear result wrong");
    AST_CLR_ENDS: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE4
        is_clr && fld_lo <= fld_hi |=> !wr_data_o[chk_lo] && !wr_data_o[chk_hi])
        else $error("field end bit not cleared");
    AST_CLR_REG_FIELDS: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE6
        is_clr_r |-> fld_hi == first_src_i[4:0] && fld_lo == first_src_i[9:5])
        else $error("register form field bounds taken from wrong bits");
    AST_CLR_FULL: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
        is_clr && fld_lo == 5'h00 && fld_hi == 5'h1F |=> wr_data_o == 32'h00000000)
        else $error("full width clear left bits set");
    AST_CLR_DST: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
        is_clr |=> wr_en_o && wr_dst_o == $past(iw[BFCN_DST_MSB:BFCN_DST_LSB]))
        else $error("clear result not written one cycle after issue");
    AST_CMP_EQ: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE12
        is_cmp && l_op == BFCN_CMP_RR && first_src_i == second_src_i[31:0]
        |=> wr_en_o && wr_data_o == 32'h00000001)
        else $error("equal operands did not give one");
    AST_CMP_BOOL: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE11
        is_cmp |=> wr_en_o && wr_data_o[31:1] == 31'h00000000)
        else $error("compare result not boolean");
    AST_NMI_ENABLE_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
        nrp_taken |=> nmi_enable_o)
        else $error("nmi enable not set by branch");
    AST_NRP_NOP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
        is_nrp && !cond_true_i |=> !pfc_load_o && $stable(pfc_o))
        else $error("false condition branch changed fetch counter");

    COV_NRP_TARGET: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        nrp_taken ##6 target_exec_o);
    COV_CLR_REG: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        is_clr_r ##1 wr_en_o);
    COV_CMP_LONG_EQ: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        is_cmp && second_source_long && cmp_eq);
    COV_NMI_ENABLE_RACE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        nrp_taken && nmi_enable_clear_i);
endmodule : bfcn_decoder
`default_nettype wire

// ### hw/bfcn_pkg.sv
`default_nettype none
package bfcn_pkg;

    // ****************************************************************
    // execution units a packet slot may be routed to
    // ****************************************************************
    typedef enum logic [1:0] {
        BFCN_SHIFT_A,
        BFCN_SHIFT_B,
        BFCN_LOGIC_A,
        BFCN_LOGIC_B
    } bfcn_unit_t;

    // ****************************************************************
    // instruction word fields
    // ****************************************************************
    localparam int BFCN_DST_MSB = 27;
    localparam int BFCN_DST_LSB = 23;
    localparam int BFCN_SECOND_SOURCE_MSB = 22;
    localparam int BFCN_SECOND_SOURCE_LSB = 18;
    localparam int BFCN_FIRST_SOURCE_MSB = 17;
    localparam int BFCN_FIRST_SOURCE_LSB = 13;
    localparam int BFCN_CSTB_MSB = 12;
    localparam int BFCN_CSTB_LSB = 8;

    // ****************************************************************
    // opcode encodings
    // ****************************************************************
    localparam logic [4:0] BFCN_NRP_SECOND_SOURCE = 5'h07;
    localparam logic [4:0] BFCN_NRP_FIRST_SOURCE = 5'h00;
    localparam logic [5:0] BFCN_NRP_OP = 6'h03;
    localparam logic [3:0] BFCN_S_TAIL_REG = 4'h8;
    localparam logic [3:0] BFCN_S_TAIL_CST = 4'h2;
    localparam logic [1:0] BFCN_CLR_CST_OP = 2'h3;
    localparam logic [5:0] BFCN_CLR_REG_OP = 6'h3F;
    localparam logic [2:0] BFCN_L_TAIL = 3'h6;
    localparam logic [6:0] BFCN_CMP_RR = 7'h53;
    localparam logic [6:0] BFCN_CMP_CR = 7'h52;
    localparam logic [6:0] BFCN_CMP_RL = 7'h51;
    localparam logic [6:0] BFCN_CMP_CL = 7'h50;

    // ****************************************************************
    // register form field bounds inside first_source
    // ****************************************************************
    localparam int BFCN_RHI_MSB = 4;
    localparam int BFCN_RHI_LSB = 0;
    localparam int BFCN_RLO_MSB = 9;
    localparam int BFCN_RLO_LSB = 5;

    // ****************************************************************
    // branch timing and reset values
    // ****************************************************************
    localparam logic [2:0] BFCN_DELAY_SLOTS = 3'h5;
    localparam logic [31:0] BFCN_PFC_RESET = 32'h00000000;
    localparam logic BFCN_NMI_ENABLE_RESET = 1'b0;

    function automatic logic [39:0] bfcn_sext5(input logic [4:0] v);
        bfcn_sext5 = {{35{v[4]}}, v};
    endfunction : bfcn_sext5

    function automatic logic [39:0] bfcn_sext32(input logic [31:0] v);
        bfcn_sext32 = {{8{v[31]}}, v};
    endfunction : bfcn_sext32

endpackage : bfcn_pkg
`default_nettype wire

// ### hw/bfcn_clr_if.sv
`default_nettype none
interface bfcn_clr_if;
    logic [31:0] second_src;
    logic [4:0] low_pos;
    logic [4:0] high_pos;
    logic [31:0] result;

    modport requester (output second_src, output low_pos, output high_pos, input result);
    modport unit (input second_src, input low_pos, input high_pos, output result);
endinterface : bfcn_clr_if
`default_nettype wire

// ### hw/bfcn_clear_unit.sv
`default_nettype none
module bfcn_clear_unit (
    // operands and result
    bfcn_clr_if.unit clr
);
    import bfcn_pkg::*;

    // bit 0 is the lsb, bit 31 the msb; an empty field (low above high) clears nothing
    always_comb
    begin
        clr.result = clr.second_src;
        for (int i = 0; i < 32; i++)
        begin
            if (5'(i) >= clr.low_pos && 5'(i) <= clr.high_pos) // RULE3 RULE4 RULE5 RULE8
            begin
                clr.result[i] = 1'b0;
            end
        end
    end
endmodule : bfcn_clear_unit
`default_nettype wire

// ### tb/bfcn_fetch_model.sv
`default_nettype none
module bfcn_fetch_model (
    // clock
    input wire logic clk_i,
    // dispatch side
    output logic issue_valid_o,
    output logic [31:0] issue_word_o,
    output bfcn_pkg::bfcn_unit_t issue_unit_o,
    output logic cond_true_o,
    output logic other_branch_o,
    output logic [31:0] first_src_o,
    output logic [39:0] second_src_o,
    // pointer and interrupt controller
    output logic [31:0] nrp_o,
    output logic nmi_enable_clear_o,
    // fetch side
    input wire logic pfc_load_i,
    input wire logic [31:0] pfc_i,
    input wire logic target_exec_i
);
    timeunit 1ns;
    timeprecision 1ns;
    import bfcn_pkg::*;

    int cnt = 0;
    int slots_seen = 0;

    initial
    begin
        issue_valid_o = 1'b0;
        issue_word_o = 32'h0;
        issue_unit_o = BFCN_SHIFT_A;
        cond_true_o = 1'b0;
        other_branch_o = 1'b0;
        first_src_o = 32'h0;
        second_src_o = 40'h0;
        nrp_o = 32'h0;
        nmi_enable_clear_o = 1'b0;
    end

    // ****************************************************************
    // dispatch: one packet per edge, all fields change together
    // ****************************************************************
    task automatic issue(input logic v, input logic [31:0] w, input bfcn_unit_t u,
        input logic c, input logic [31:0] a, input logic [39:0] b, input logic ob);
        logic nrp_br;
        nrp_br = v && c && w[22:18] == BFCN_NRP_SECOND_SOURCE && w[11:6] == BFCN_NRP_OP;
        @(posedge clk_i);
        issue_valid_o <= v;
        issue_word_o <= w;
        issue_unit_o <= u;
        cond_true_o <= c;
        // a second taken branch never shares a packet with this one
        other_branch_o <= ob && !nrp_br;
        // software keeps the unused bound bits clear
        first_src_o <= (w[11:6] == BFCN_CLR_REG_OP) ? {22'h0, a[9:0]} : a;
        second_src_o <= b;
    endtask : issue

    task automatic set_ptr(input logic [31:0] p, input logic clr);
        @(posedge clk_i);
        nrp_o <= p;
        nmi_enable_clear_o <= clr;
    endtask : set_ptr

    // ****************************************************************
    // fetch: packets run from the load cycle up to the target
    // ****************************************************************
    always @(posedge clk_i)
    begin
        cnt <= pfc_load_i ? 0 : cnt + 1;
        // the load cycle itself is the first delay slot
        if (target_exec_i)
            slots_seen <= cnt + 1;
    end
endmodule : bfcn_fetch_model
`default_nettype wire

// ### tb/bitfield_clear_compare_nmi_branch_tb.sv
`default_nettype none
module bitfield_clear_compare_nmi_branch_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bfcn_pkg::*;

    localparam logic [12:0] reg_low = {1'b0, BFCN_CLR_REG_OP, BFCN_S_TAIL_REG, 2'h0};
    localparam logic [31:0] nrp_word = {9'h000, BFCN_NRP_SECOND_SOURCE, BFCN_NRP_FIRST_SOURCE, 1'b0,
        BFCN_NRP_OP, BFCN_S_TAIL_REG, 2'h0};

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid, cond, ob, nclr, pfc_load, nmi_enable, no_int, tgt, wr_en;
    logic [31:0] word, a, nmi_return_pointer, program_fetch_counter, wr_data;
    logic [39:0] b;
    logic [4:0] wr_dst;
    bfcn_unit_t unit, wr_unit;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    logic p_en = 1'b0;
    logic [4:0] p_dst;
    logic [31:0] p_data;
    bfcn_unit_t p_unit;

    always #20 clk = ~clk;

    bfcn_fetch_model dsp (.clk_i(clk), .issue_valid_o(valid), .issue_word_o(word),
        .issue_unit_o(unit), .cond_true_o(cond), .other_branch_o(ob), .first_src_o(a),
        .second_src_o(b), .nrp_o(nmi_return_pointer), .nmi_enable_clear_o(nclr), .pfc_load_i(pfc_load),
        .pfc_i(program_fetch_counter), .target_exec_i(tgt));

    bfcn_decoder uut (.clk_i(clk), .rst_n_i(rst_n), .issue_valid_i(valid),
        .issue_word_i(word), .issue_unit_i(unit), .cond_true_i(cond), .other_branch_i(ob),
        .first_src_i(a), .second_src_i(b), .nrp_i(nmi_return_pointer), .nmi_enable_clear_i(nclr),
        .pfc_load_o(pfc_load), .pfc_o(program_fetch_counter), .nmi_enable_o(nmi_enable), .no_interrupt_o(no_int),
        .target_exec_o(tgt), .wr_en_o(wr_en), .wr_unit_o(wr_unit), .wr_dst_o(wr_dst),
        .wr_data_o(wr_data));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] mkw(input logic [4:0] f1, input logic [12:0] low,
        input logic [4:0] dst);
        return {4'h0, dst, 5'h02, f1, low};
    endfunction : mkw

    function automatic logic [31:0] cleared(input logic [31:0] v, input int lo, input int hi);
        for (int i = lo; i <= hi; i++)
            v[i] = 1'b0;
        return v;
    endfunction : cleared

    task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // issues one packet and judges the result of the packet before it
    task automatic send(input logic v, input logic [31:0] w, input bfcn_unit_t u, input logic c,
        input logic [31:0] x, input logic [39:0] y, input logic o, input logic en,
        input logic [31:0] d);
        dsp.issue(v, w, u, c, x, y, o);
        #1;
        chk("wr_en", 40'(p_en), 40'(wr_en));
        if (p_en)
        begin
            chk("wr_data", 40'(p_data), 40'(wr_data));
            chk("wr_dst", 40'(p_dst), 40'(wr_dst));
            chk("wr_unit", 40'(p_unit), 40'(wr_unit));
        end
        p_en = en;
        p_dst = w[27:23];
        p_data = d;
        p_unit = u;
    endtask : send

    task automatic idle;
        send(1'b0, 32'h0, BFCN_SHIFT_A, 1'b0, 32'h0, 40'h0, 1'b0, 1'b0, 32'h0);
    endtask : idle

    task automatic walk(input int k0, input int k1, input int ld, input int tg, input int last);
        for (int k = k0; k <= k1; k++)
        begin
            chk("pfc_load", 40'(k == ld), 40'(pfc_load));
            chk("target_exec", 40'(k == tg), 40'(tgt));
            chk("no_interrupt", 40'(k >= 1 && k <= last), 40'(no_int));
            @(posedge clk);
            #1;
        end
    endtask : walk

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_clear;
        logic [4:0] lo [5] = '{5'h00, 5'h0F, 5'h00, 5'h1F, 5'h05};
        logic [4:0] hi [5] = '{5'h1F, 5'h17, 5'h00, 5'h1F, 5'h04};
        logic [31:0] v;
        for (int i = 0; i < 5; i++)
        begin
            v = i[0] ? 32'hA5C3_5A3C : 32'hFFFF_FFFF;
            send(1'b1, mkw(lo[i], {hi[i], BFCN_CLR_CST_OP, BFCN_S_TAIL_CST, 2'h0}, 5'(i + 1)),
                bfcn_unit_t'(i[0]), 1'b1, 32'h0, {8'h5A, v}, 1'b0, 1'b1,
                cleared(v, lo[i], hi[i]));
        end
        send(1'b1, mkw(5'h01, reg_low, 5'h0A), BFCN_SHIFT_B, 1'b1, 32'h0000_0052,
            40'h00_03B6_E7D5, 1'b0, 1'b1, 32'h03B0_0001);
        send(1'b1, mkw(5'h01, reg_low, 5'h0B), BFCN_SHIFT_A, 1'b1, 32'h0000_001F,
            40'h00_A5C3_5A3C, 1'b0, 1'b1, 32'h0);
        idle();
    endtask : t_clear

    task automatic t_cmp;
        logic [6:0] op [8] = '{BFCN_CMP_RR, BFCN_CMP_RR, BFCN_CMP_CR, BFCN_CMP_CR,
            BFCN_CMP_RL, BFCN_CMP_RL, BFCN_CMP_CL, BFCN_CMP_CL};
        logic [4:0] cst [8] = '{5'h00, 5'h00, 5'h1F, 5'h1F, 5'h00, 5'h00, 5'h10, 5'h10};
        logic [31:0] x [8] = '{32'h1234_5678, 32'h9234_5678, 32'h0, 32'h0,
            32'h8000_0000, 32'h8000_0000, 32'h0, 32'h0};
        logic [39:0] y [8] = '{40'hAB_1234_5678, 40'h00_1234_5678, 40'h00_FFFF_FFFF,
            40'h00_0000_001F, 40'hFF_8000_0000, 40'h00_8000_0000, 40'hFF_FFFF_FFF0,
            40'h00_FFFF_FFF0};
        for (int i = 0; i < 8; i++)
            send(1'b1, mkw(cst[i], {1'b0, op[i], BFCN_L_TAIL, 2'h0}, 5'(i + 3)),
                bfcn_unit_t'({1'b1, i[0] ^ i[1]}), 1'b1, x[i], y[i], 1'b0, 1'b1,
                32'(!i[0]));
        idle();
    endtask : t_cmp

    task automatic t_refuse;
        send(1'b1, mkw(5'h00, {5'h1F, BFCN_CLR_CST_OP, BFCN_S_TAIL_CST, 2'h0}, 5'h01),
            BFCN_LOGIC_A, 1'b1, 32'h0, 40'hFF, 1'b0, 1'b0, 32'h0);
        send(1'b1, mkw(5'h00, {1'b0, BFCN_CMP_RR, BFCN_L_TAIL, 2'h0}, 5'h02),
            BFCN_SHIFT_B, 1'b1, 32'h0, 40'h0, 1'b0, 1'b0, 32'h0);
        send(1'b1, mkw(5'h00, {5'h1F, BFCN_CLR_CST_OP, BFCN_S_TAIL_CST, 2'h0}, 5'h03),
            BFCN_SHIFT_A, 1'b0, 32'h0, 40'hFF, 1'b0, 1'b0, 32'h0);
        send(1'b1, mkw(5'h00, {1'b0, 7'h7F, BFCN_L_TAIL, 2'h0}, 5'h04),
            BFCN_LOGIC_A, 1'b1, 32'h0, 40'h0, 1'b0, 1'b0, 32'h0);
        idle();
    endtask : t_refuse

    task automatic t_branch;
        dsp.set_ptr(32'h0000_1000, 1'b0);
        send(1'b1, nrp_word, BFCN_SHIFT_B, 1'b1, 32'h0, 40'h0, 1'b0, 1'b0, 32'h0);
        idle();
        walk(1, 7, 1, 6, 5);
        chk("pfc", 40'h1000, 40'(program_fetch_counter));
        chk("nmi_enable", 40'h1, 40'(nmi_enable));
        chk("slots", 40'h5, 40'(dsp.slots_seen));
        dsp.set_ptr(32'h0000_2000, 1'b1);
        dsp.set_ptr(32'h0000_2000, 1'b0);
        send(1'b1, nrp_word, BFCN_SHIFT_B, 1'b0, 32'h0, 40'h0, 1'b0, 1'b0, 32'h0);
        idle();
        walk(1, 7, 99, 99, 5);
        chk("pfc", 40'h1000, 40'(program_fetch_counter));
        chk("nmi_enable", 40'h0, 40'(nmi_enable));
        send(1'b1, nrp_word, BFCN_SHIFT_B, 1'b1, 32'h0, 40'h0, 1'b0, 1'b0, 32'h0);
        idle();
        send(1'b1, 32'h0, BFCN_SHIFT_A, 1'b0, 32'h0, 40'h0, 1'b1, 1'b0, 32'h0);
        idle();
        walk(3, 9, 99, 99, 7);
        chk("pfc", 40'h2000, 40'(program_fetch_counter));
    endtask : t_branch

    task automatic complete_run;
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            failures++;
            complete_run();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("pfc_reset", 40'h0, 40'(program_fetch_counter));
        chk("nmi_enable_reset", 40'h0, 40'(nmi_enable));
        t_clear();
        t_cmp();
        t_refuse();
        t_branch();
        complete_run();
    end
endmodule : bitfield_clear_compare_nmi_branch_tb
`default_nettype wire
